// ===== rtl/bbp_defs.vh
/*
 * bbp_defs.vh - constants for the bit-bang parallel port.
 * assumes: included by bare name from rtl/ design files.
 */
`ifndef BBP_DEFS_VH
`define BBP_DEFS_VH

`define BBP_MODE_RESET 8'h00
`define BBP_MODE_ASYNC 8'h01
`define BBP_MODE_SYNC 8'h04
`define BBP_DIR_RESET 8'h00
`define BBP_PINS_RESET 8'h00
`define BBP_PIN_RESET_BIT 1'b0
`define BBP_BAUD_DIV_DEF 16'h0064
`define BBP_FIFO_DEPTH_DEF 32

`endif

// ===== rtl/bbp_fifo.v
/*
 * bbp_fifo.v - no logic of its own.
 * assumes: the bbp_fifo module is defined in bbp_port.v with the rest of the port.
 */

// ===== rtl/bbp_port.v
/*
 * bbp_port.v - eight-bit bit-bang parallel port, async and sync modes.
 * assumes: host side delivers bytes as same-clock valid/ready streams and setup
 * commands as same-clock strobes with no ready; pins are asynchronous and synchronised here.
 */
`include "bbp_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module bbp_port #(
    parameter BAUD_DIV = `BBP_BAUD_DIV_DEF,
    parameter FIFO_DEPTH = `BBP_FIFO_DEPTH_DEF,
    parameter FIFO_AW = 5
) (
    input wire mclk_i, // 100 MHz clock
    input wire sys_rst_i, // async reset, high
    input wire setup_valid_i, // setup command strobe
    input wire [7:0] setup_mode_i, // bit-mode code
    input wire [7:0] setup_mask_i, // direction mask
    input wire [7:0] dn_data_i, // byte from host
    input wire dn_valid_i, // byte valid
    output wire dn_ready_o, // downstream buffer has room
    output reg [7:0] up_data_o, // sample to host
    output reg up_valid_o, // sample valid
    input wire up_ready_i, // host takes sample
    input wire [7:0] pin_in_i, // pin levels
    output reg [7:0] pin_out_o, // pin drive value
    output reg [7:0] pin_oe_o, // pin drive enable
    output reg pin_sample_strobe_n_o, // read strobe, low active
    output reg pin_update_strobe_n_o // write strobe, low active
);
    localparam ST_IDLE = 3'd0;
    localparam ST_SAMPLE = 3'd1;
    localparam ST_SEND = 3'd2;
    localparam ST_DRIVE = 3'd3;
    localparam ST_SETUP = 3'd4;
    localparam ST_WSTB = 3'd5;

    reg [7:0] pin_meta_r;
    reg [7:0] pin_sync_r;
    reg [7:0] mode_r;
    reg [2:0] state_r;
    reg [15:0] baud_cnt_r;
    reg baud_tick_r;
    reg [7:0] sample_r;
    reg [7:0] byte_r;
    reg up_push_r;
    reg async_wstb_r;

    wire [7:0] dnb_data;
    wire dnb_valid;
    reg dnb_pop;
    wire [7:0] upb_data;
    wire upb_valid;
    wire upb_ready;

    // one compare shape for every mode decode
    function mode_is;
        input [7:0] mode;
        input [7:0] code;
        begin
            mode_is = (mode == code);
        end
    endfunction

    wire mode_async = mode_is(mode_r, `BBP_MODE_ASYNC);
    wire mode_sync = mode_is(mode_r, `BBP_MODE_SYNC);

    bbp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_downstream_buffer (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .in_data_i(dn_data_i),
        .in_valid_i(dn_valid_i),
        .in_ready_o(dn_ready_o),
        .out_data_o(dnb_data),
        .out_valid_o(dnb_valid),
        .out_ready_i(dnb_pop)
    );

    // upstream buffer drained through a registered output stage
    bbp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_upstream_buffer (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .in_data_i(sample_r),
        .in_valid_i(up_push_r),
        .in_ready_o(upb_ready),
        .out_data_o(upb_data),
        .out_valid_o(upb_valid),
        .out_ready_i(upb_valid && (!up_valid_o || up_ready_i))
    );

    always @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            up_data_o <= `BBP_PINS_RESET;
            up_valid_o <= 1'b0;
        end else if (!up_valid_o || up_ready_i) begin
            up_data_o <= upb_data;
            up_valid_o <= upb_valid;
        end
    end

    // two-stage synchroniser per pin; only pin_sync_r feeds logic
    // pins are independent, so no bus-wide coherence is promised
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin_sync
            always @(posedge mclk_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    pin_meta_r[gi] <= `BBP_PIN_RESET_BIT;
                    pin_sync_r[gi] <= `BBP_PIN_RESET_BIT;
                end else begin
                    pin_meta_r[gi] <= pin_in_i[gi];
                    pin_sync_r[gi] <= pin_meta_r[gi];
                end
            end
        end
    endgenerate

    // mode and direction change only on a setup command
    always @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mode_r <= `BBP_MODE_RESET;
            pin_oe_o <= `BBP_DIR_RESET;
        end else if (setup_valid_i) begin
            mode_r <= setup_mode_i;
            pin_oe_o <= setup_mask_i;
        end
    end

    // baud generator free-runs; tick is one cycle wide
    always @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            baud_cnt_r <= 16'h0000;
            baud_tick_r <= 1'b0;
        end else if (baud_cnt_r == BAUD_DIV[15:0] - 16'h0001) begin
            baud_cnt_r <= 16'h0000;
            baud_tick_r <= 1'b1;
        end else begin
            baud_cnt_r <= baud_cnt_r + 16'h0001;
            baud_tick_r <= 1'b0;
        end
    end

    always @* begin
        dnb_pop = 1'b0;
        if (mode_async && baud_tick_r && dnb_valid) begin
            dnb_pop = 1'b1;
        end else if (mode_sync && state_r == ST_IDLE && dnb_valid && upb_ready) begin
            dnb_pop = 1'b1;
        end
    end

    always @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_r <= ST_IDLE;
            pin_out_o <= `BBP_PINS_RESET;
            pin_sample_strobe_n_o <= 1'b1;
            pin_update_strobe_n_o <= 1'b1;
            sample_r <= `BBP_PINS_RESET;
            byte_r <= `BBP_PINS_RESET;
            up_push_r <= 1'b0;
            async_wstb_r <= 1'b0;
        end else begin
            up_push_r <= 1'b0;
            async_wstb_r <= 1'b0;
            if (mode_async) begin
                state_r <= ST_IDLE;
                pin_sample_strobe_n_o <= !baud_tick_r;
                pin_update_strobe_n_o <= !async_wstb_r;
                if (baud_tick_r) begin
                    sample_r <= pin_sync_r;
                    up_push_r <= upb_ready; // free-running samples drop when full
                end
                if (dnb_pop) begin
                    pin_out_o <= dnb_data;
                    async_wstb_r <= 1'b1;
                end
            end else if (mode_sync) begin
                case (state_r)
                    ST_IDLE: begin
                        pin_sample_strobe_n_o <= 1'b0;
                        pin_update_strobe_n_o <= 1'b1;
                        if (dnb_pop) begin
                            byte_r <= dnb_data;
                            sample_r <= pin_sync_r;
                            state_r <= ST_SAMPLE;
                        end
                    end
                    ST_SAMPLE: begin
                        pin_sample_strobe_n_o <= 1'b1;
                        up_push_r <= 1'b1;
                        state_r <= ST_SEND;
                    end
                    ST_SEND: begin
                        pin_sample_strobe_n_o <= 1'b0;
                        pin_out_o <= byte_r;
                        state_r <= ST_DRIVE;
                    end
                    ST_DRIVE: begin
                        state_r <= ST_SETUP;
                    end
                    ST_SETUP: begin
                        pin_update_strobe_n_o <= 1'b0;
                        state_r <= ST_WSTB;
                    end
                    ST_WSTB: begin
                        pin_update_strobe_n_o <= 1'b1;
                        state_r <= ST_IDLE;
                    end
                    default: begin
                        state_r <= ST_IDLE;
                    end
                endcase
            end else begin
                // other modes leave the pins parked
                state_r <= ST_IDLE;
                pin_sample_strobe_n_o <= 1'b1;
                pin_update_strobe_n_o <= 1'b1;
            end
        end
    end
endmodule // bbp_port

// synchronous valid/ready fifo; depth must be a power of two
module bbp_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    input wire mclk_i, // clock
    input wire sys_rst_i, // async reset, high
    input wire [WIDTH-1:0] in_data_i, // write data
    input wire in_valid_i, // write request
    output wire in_ready_o, // not full, registered
    output wire [WIDTH-1:0] out_data_o, // head word
    output wire out_valid_o, // not empty
    input wire out_ready_i // pop
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wr_ptr_r;
    reg [AW:0] rd_ptr_r;
    reg in_ready_r;
    wire empty = (wr_ptr_r == rd_ptr_r);
    wire full = (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]) && (wr_ptr_r[AW] != rd_ptr_r[AW]);
    wire push = in_valid_i && !full;
    wire pop = out_ready_i && !empty;
    wire [AW:0] wr_ptr_nxt = wr_ptr_r + {{AW{1'b0}}, push};
    wire [AW:0] rd_ptr_nxt = rd_ptr_r + {{AW{1'b0}}, pop};
    // ready from a flop keeps the pointer compare off the host's path
    wire full_nxt = (wr_ptr_nxt[AW-1:0] == rd_ptr_nxt[AW-1:0]) &&
        (wr_ptr_nxt[AW] != rd_ptr_nxt[AW]);

    assign in_ready_o = in_ready_r;
    assign out_valid_o = !empty;
    assign out_data_o = mem[rd_ptr_r[AW-1:0]];

    always @(posedge mclk_i) begin
        if (push) begin
            mem[wr_ptr_r[AW-1:0]] <= in_data_i;
        end
    end

    always @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wr_ptr_r <= {(AW+1){1'b0}};
            rd_ptr_r <= {(AW+1){1'b0}};
            in_ready_r <= 1'b1;
        end else begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            in_ready_r <= !full_nxt;
        end
    end
endmodule // bbp_fifo

`default_nettype wire

// ===== verif/bbp_port_sva.sv
/* bbp_port checker: port-level timing of strobes, pins and enables.
   assumes: bound to bbp_port, mode codes 1 async and 4 sync. */
`timescale 1ns/1ps
`default_nettype none
module bbp_port_chk (
    input wire mclk_i, // clock
    input wire sys_rst_i, // reset
    input wire setup_valid_i, // setup pulse
    input wire [7:0] setup_mode_i, // mode code
    input wire [7:0] setup_mask_i, // mask
    input wire up_valid_o, // sample valid
    input wire [7:0] pin_out_o, // drive value
    input wire [7:0] pin_oe_o, // enables
    input wire pin_sample_strobe_n_o, // read strobe
    input wire pin_update_strobe_n_o // write strobe
);
reg [7:0] mode_r;
reg idl_r;
wire syn = mode_r == 8'h04;
wire asy = mode_r == 8'h01;
// idle must hold a cycle before strobes are parked
always @(posedge mclk_i or posedge sys_rst_i)
    if (sys_rst_i) idl_r <= 1'b1;
    else idl_r <= !syn && !asy;
always @(posedge mclk_i or posedge sys_rst_i)
    if (sys_rst_i) mode_r <= 8'h00;
    else if (setup_valid_i) mode_r <= setup_mode_i;
default clocking cb @(posedge mclk_i); endclocking
default disable iff (sys_rst_i);
chk_oe_mask:
assert property (setup_valid_i |=> pin_oe_o == $past(setup_mask_i)) else $error("oe not mask");
chk_oe_hold:
assert property (!setup_valid_i |=> $stable(pin_oe_o)) else $error("oe moved");
chk_sync_wr:
assert property (syn && $changed(pin_out_o) |-> ##2 !pin_update_strobe_n_o)
    else $error("sync drive without write strobe");
chk_sync_order:
assert property (syn && $rose(pin_sample_strobe_n_o) |=> $fell(pin_sample_strobe_n_o)
    ##2 !pin_update_strobe_n_o ##1 pin_update_strobe_n_o) else $error("sync order");
chk_sample_up:
assert property (syn && $rose(pin_sample_strobe_n_o) |-> ##[1:4] up_valid_o)
    else $error("sample not sent up");
chk_async_wr:
assert property (asy && $changed(pin_out_o) |=> !pin_update_strobe_n_o)
    else $error("async drive without strobe");
chk_wr_pulse:
assert property ($fell(pin_update_strobe_n_o) |=> pin_update_strobe_n_o) else $error("wr width");
chk_idle_park:
assert property (idl_r && !syn && !asy |-> pin_sample_strobe_n_o && pin_update_strobe_n_o)
    else $error("strobes not parked");
endmodule // bbp_port_chk
bind bbp_port bbp_port_chk chk_u (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .setup_valid_i(setup_valid_i), .setup_mode_i(setup_mode_i), .setup_mask_i(setup_mask_i),
    .up_valid_o(up_valid_o), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o),
    .pin_sample_strobe_n_o(pin_sample_strobe_n_o), .pin_update_strobe_n_o(pin_update_strobe_n_o));
`default_nettype wire

// ===== verif/bbp_ext.sv
/* external logic on the port pins, counting the access strobes.
   assumes: undriven pins show the level the far side applies. */
`timescale 1ns/1ps
`default_nettype none
module bbp_ext (
    input wire logic rst_i, // reset
    input wire logic [7:0] pin_out_i, // drive value
    input wire logic [7:0] pin_oe_i, // enables
    input wire logic rd_n_i, // sample strobe
    input wire logic wr_n_i, // update strobe
    input wire logic [7:0] ext_i, // far-side level
    output logic [7:0] pin_o, // wire level
    output logic [7:0] n_wr_o, // update count
    output logic [7:0] n_rd_o // sample count
);
assign pin_o = (pin_out_i & pin_oe_i) | (ext_i & ~pin_oe_i);
always @(posedge wr_n_i or posedge rst_i)
    if (rst_i) n_wr_o <= 8'h00;
    else n_wr_o <= n_wr_o + 8'h01;
always @(posedge rd_n_i or posedge rst_i)
    if (rst_i) n_rd_o <= 8'h00;
    else n_rd_o <= n_rd_o + 8'h01;
endmodule // bbp_ext
`default_nettype wire

// ===== verif/test_bit_bang_parallel_port.sv
/* bench for bbp_port: one task per scenario, pins looped through bbp_ext.
   assumes: design, checker and bbp_ext compiled first. */
`timescale 1ns/1ps
`default_nettype none
module test_bit_bang_parallel_port;
logic mclk_i = 1'b0;
logic sys_rst_i = 1'b1;
logic setup_valid_i = 1'b0;
logic dn_valid_i = 1'b0;
logic up_ready_i = 1'b0;
logic [7:0] setup_mode_i = 8'h00;
logic [7:0] setup_mask_i = 8'h00;
logic [7:0] dn_data_i = 8'h00;
logic [7:0] ext = 8'h00;
logic [7:0] c;
logic [7:0] got [0:127];
wire dn_ready_o, up_valid_o, rd_n, wr_n;
wire [7:0] up_data_o, pin_in, pin_out_o, pin_oe_o, nw, nr;
int n_errors = 0;
int n_compared = 0;
int cyc = 0;
int n;
always #5 mclk_i = ~mclk_i;
bbp_port #(.BAUD_DIV(4)) dut_u (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .setup_valid_i(setup_valid_i), .setup_mode_i(setup_mode_i), .setup_mask_i(setup_mask_i),
    .dn_data_i(dn_data_i), .dn_valid_i(dn_valid_i), .dn_ready_o(dn_ready_o),
    .up_data_o(up_data_o), .up_valid_o(up_valid_o), .up_ready_i(up_ready_i),
    .pin_in_i(pin_in), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o),
    .pin_sample_strobe_n_o(rd_n), .pin_update_strobe_n_o(wr_n));
bbp_ext ext_u (.rst_i(sys_rst_i), .pin_out_i(pin_out_o), .pin_oe_i(pin_oe_o), .rd_n_i(rd_n),
    .wr_n_i(wr_n), .ext_i(ext), .pin_o(pin_in), .n_wr_o(nw), .n_rd_o(nr));
task wrap_up;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
endtask
always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 5000) begin
        n_errors++;
        wrap_up;
    end
end
task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
        n_errors++;
        $display("Error %s expected %h seen %h", nm, exp, seen);
    end
endtask
task setup(input logic [7:0] md, input logic [7:0] mk);
    setup_mode_i <= md;
    setup_mask_i <= mk;
    setup_valid_i <= 1'b1;
    @(posedge mclk_i);
    setup_valid_i <= 1'b0;
    @(negedge mclk_i);
    chk("oe", pin_oe_o, mk);
    @(posedge mclk_i);
endtask
// valid stays up; the caller lowers it after a batch
task push(input logic [7:0] b);
    dn_data_i <= b;
    dn_valid_i <= 1'b1;
    do @(negedge mclk_i); while (dn_ready_o !== 1'b1);
    @(posedge mclk_i);
endtask
task pull(input int k);
    up_ready_i <= 1'b1;
    for (int i = 0; i < k; i++) begin
        do @(negedge mclk_i); while (up_valid_o !== 1'b1);
        got[i] = up_data_o;
        @(posedge mclk_i);
    end
    up_ready_i <= 1'b0;
endtask
task t_reset;
    @(negedge mclk_i);
    chk("rst pins", pin_out_o | pin_oe_o, 8'h00);
    chk("rst strobes", {6'h00, rd_n, wr_n}, 8'h03);
    @(posedge mclk_i);
    $display("reset test done");
endtask
task t_sync;
    setup(8'h04, 8'hff);
    c = nw;
    push(8'h55);
    push(8'haa);
    push(8'haa);
    dn_valid_i <= 1'b0;
    pull(3);
    repeat (4) @(posedge mclk_i);
    chk("s0", got[0], 8'h00);
    chk("s1", got[1], 8'h55);
    chk("s2", got[2], 8'haa);
    chk("pins", pin_out_o, 8'haa);
    chk("wr count", nw - c, 8'h03);
    $display("sync test done");
endtask
task t_mix;
    ext <= 8'h0f;
    setup(8'h04, 8'hf0);
    push(8'h5a);
    push(8'ha5);
    dn_valid_i <= 1'b0;
    pull(2);
    chk("m0", got[0], 8'haf);
    chk("m1", got[1], 8'h5f);
    $display("mixed test done");
endtask
task t_inp;
    ext <= 8'h3c;
    setup(8'h04, 8'h00);
    push(8'h11);
    push(8'h22);
    dn_valid_i <= 1'b0;
    pull(2);
    chk("i0", got[0], 8'h3c);
    chk("i1", got[1], 8'h3c);
    $display("inputs test done");
endtask
// host stalls: upstream fills, then pops must stop
task t_full;
    setup(8'h04, 8'hff);
    n = 0;
    dn_data_i <= 8'h00;
    dn_valid_i <= 1'b1;
    forever begin
        @(negedge mclk_i);
        if (dn_ready_o !== 1'b1) break;
        @(posedge mclk_i);
        n++;
        dn_data_i <= n[7:0];
    end
    @(posedge mclk_i);
    dn_valid_i <= 1'b0;
    repeat (300) @(posedge mclk_i);
    c = nw;
    repeat (60) @(posedge mclk_i);
    chk("stall", nw - c, 8'h00);
    pull(n);
    @(negedge mclk_i);
    chk("first", got[1], 8'h00);
    chk("last", got[n-1], n[7:0] - 8'h02);
    chk("empty", {7'h00, up_valid_o}, 8'h00);
    @(posedge mclk_i);
    $display("full test done");
endtask
task t_async;
    setup(8'h01, 8'hff);
    push(8'h3c);
    dn_valid_i <= 1'b0;
    repeat (20) @(posedge mclk_i);
    chk("a0", pin_out_o, 8'h3c);
    c = nw;
    n = nr;
    repeat (20) @(posedge mclk_i);
    chk("hold", pin_out_o, 8'h3c);
    chk("no wr", nw - c, 8'h00);
    chk("rd ticks", nr - n[7:0], 8'h05);
    push(8'hc3);
    dn_valid_i <= 1'b0;
    repeat (20) @(posedge mclk_i);
    chk("a1", pin_out_o, 8'hc3);
    setup(8'h00, 8'h00);
    $display("async test done");
endtask
initial begin
    repeat (5) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    @(posedge mclk_i);
    t_reset;
    t_sync;
    t_mix;
    t_inp;
    t_full;
    t_async;
    wrap_up;
end
endmodule // test_bit_bang_parallel_port
`default_nettype wire
